/* rtl/ths_defs.svh */
// Register offsets, field positions and reset values of the scheduler
`ifndef THS_DEFS_SVH
`define THS_DEFS_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define THS_OFF_CTRL      8'h00
`define THS_OFF_SEL       8'h04
`define THS_OFF_STATE     8'h08
`define THS_OFF_PC        8'h0C
`define THS_OFF_STATUS    8'h10
`define THS_OFF_TPTR      8'h14
`define THS_OFF_GIDX      8'h18
`define THS_OFF_GDATA     8'h1C
`define THS_OFF_MHI       8'h20
`define THS_OFF_MLO       8'h24
`define THS_OFF_ELIG      8'h28
`define THS_OFF_VSYS      8'h2C

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define THS_CTRL_CFG      0
`define THS_CTRL_VEN_LSB  8
`define THS_SEL_VPE_LSB   8
`define THS_ST_ACT        0
`define THS_ST_HALT       1
`define THS_ST_DA         2
`define THS_ST_PARK       3
`define THS_ST_BLK        4
`define THS_ST_SUSP       5
`define THS_ST_VPE_LSB    8
`define THS_SR_CU_LSB     0
`define THS_SR_MX         4
`define THS_SR_KSU_LSB    5
`define THS_SR_SST        7
`define THS_SR_ADDRESS_SPACE_ID_LSB   8

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define THS_RST_VPE_EN    1
`define THS_RST_KSU       2'h0

`endif

/* rtl/ths_pkg.sv */
// Types shared by the thread context scheduler
package ths_pkg;
    typedef logic [31:0] ths_word_t;
    typedef enum logic [1:0] {
        THS_KERNEL = 2'h0,
        THS_SUPER  = 2'h1,
        THS_USER   = 2'h2
    } ths_ksu_e;
endpackage

/* rtl/ths_sched.sv */
// Thread context state tracker and issue scheduler with AHB-Lite registers
//
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "ths_defs.svh"
// Operation
// RULE1: Per-context registers, counter, status fields, pointer
// RULE2: Legacy system state held once per element
// RULE3: Every element keeps at least one context
// RULE4: Free context never fetches or issues
// RULE5: Only activated contexts are scheduling candidates
// RULE6: Creation allocates only free contexts
// RULE7: Create/thread_instr_a touch only dynamically allocatable contexts
// RULE8: Allocation by software or by instructions
// RULE9: Unsatisfied synchronisation holds context blocked
// RULE10: Halted context never allocated nor issued
// RULE11: Halted context state stays stable
// RULE12: Suspended context may not raise exceptions
// RULE13: Debug-parked context is never scheduled
// RULE14: Privileged access to target context registers
// RULE15: Gated storage access blocks until satisfied
// RULE16: Any policy; blocked contexts hold nothing
// RULE17: After reset one element runs from vector
// RULE18: Rebinding only in configuration state
// RULE19: Eligibility recomputed every cycle from flags
module ths_sched #(
    parameter int          N_TC     = 4,
    parameter int          N_VPE    = 2,
    parameter int          N_GPR    = 32,
    parameter logic [31:0] RESET_PC = 32'h0000_0000
) (
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [3:0]                hprot,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic      [31:0]               hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    input  wire logic                      pc_upd_valid,
    input  wire logic [$clog2(N_TC)-1:0]   pc_upd_tc,
    input  wire logic [31:0]               pc_upd_value,
    input  wire logic                      wb_valid,
    input  wire logic [$clog2(N_TC)-1:0]   wb_tc,
    input  wire logic [$clog2(N_GPR)-1:0]  wb_idx,
    input  wire logic [31:0]               wb_data,
    input  wire logic [N_TC-1:0]           block_set,
    input  wire logic [N_TC-1:0]           block_clr,
    input  wire logic [N_TC-1:0]           suspend_in,
    input  wire logic                      create_valid,
    input  wire logic [$clog2(N_TC)-1:0]   create_src,
    input  wire logic [31:0]               create_pc,
    input  wire logic                      thread_instr_a_valid,
    input  wire logic [$clog2(N_TC)-1:0]   thread_instr_a_src,
    output logic                           create_done,
    output logic                           create_ok,
    output logic      [$clog2(N_TC)-1:0]   create_tc,
    output logic                           thread_instr_a_done,
    output logic                           thread_instr_a_ok,
    output logic                           issue_valid,
    output logic      [$clog2(N_TC)-1:0]   issue_tc,
    output logic      [31:0]               issue_pc,
    output logic      [N_TC-1:0]           eligible,
    output logic      [N_TC-1:0]           exc_permit
);
    localparam int TW = $clog2(N_TC);
    localparam int VW = (N_VPE > 1) ? $clog2(N_VPE) : 1;
    localparam int GW = $clog2(N_GPR);

    // ---------------------------------------------------------------
    // State storage
    // ---------------------------------------------------------------
    logic [N_TC-1:0]          act_reg;
    logic [N_TC-1:0]          halt_reg;
    logic [N_TC-1:0]          da_reg;
    logic [N_TC-1:0]          park_reg;
    logic [N_TC-1:0]          blk_reg;
    logic [N_TC-1:0]          susp_reg;
    logic [N_TC-1:0][VW-1:0]  vpe_reg;
    logic [N_TC-1:0][31:0]    pc_reg;
    logic [3:0]               cu_reg    [N_TC];
    logic                     mx_reg    [N_TC];
    ths_pkg::ths_ksu_e        ksu_reg   [N_TC];
    logic                     sst_reg   [N_TC];
    logic [7:0]               address_space_id_reg  [N_TC];
    ths_pkg::ths_word_t       tptr_reg  [N_TC];
    ths_pkg::ths_word_t       mhi_reg   [N_TC];
    ths_pkg::ths_word_t       mlo_reg   [N_TC];
    ths_pkg::ths_word_t       gpr_mem   [N_TC][N_GPR];
    ths_pkg::ths_word_t       vsys_reg  [N_VPE];
    logic                     cfg_reg;
    logic [N_VPE-1:0]         ven_reg;
    logic [TW-1:0]            sel_tc_reg;
    logic [VW-1:0]            sel_vpe_reg;
    logic [GW-1:0]            gidx_reg;
    logic [TW-1:0]            last_reg;
    logic                     wr_pend_reg;
    logic [7:0]               wr_addr_reg;
    logic                     wr_priv_reg;

    // ---------------------------------------------------------------
    // AHB-Lite slave
    // ---------------------------------------------------------------
    logic                     ahb_take;
    ths_pkg::ths_word_t       rd_mux;

    assign ahb_take = hsel && htrans[1] && hready;
    assign hresp    = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_priv_reg <= 1'b0;
            hreadyout   <= 1'b1;
        end else begin
            wr_pend_reg <= ahb_take && hwrite;
            wr_addr_reg <= haddr[7:0];
            wr_priv_reg <= hprot[1];
            hreadyout   <= 1'b1;
        end
    end

    logic                     wr_en;
    logic                     wr_state;
    logic                     wr_pc;

    assign wr_en    = wr_pend_reg && wr_priv_reg; // RULE14
    assign wr_state = wr_en && (wr_addr_reg == `THS_OFF_STATE);
    assign wr_pc    = wr_en && (wr_addr_reg == `THS_OFF_PC);

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            `THS_OFF_CTRL: begin
                rd_mux[`THS_CTRL_CFG] = cfg_reg;
                rd_mux[`THS_CTRL_VEN_LSB +: N_VPE] = ven_reg;
            end
            `THS_OFF_SEL: begin
                rd_mux[TW-1:0] = sel_tc_reg;
                rd_mux[`THS_SEL_VPE_LSB +: VW] = sel_vpe_reg;
            end
            `THS_OFF_STATE: begin
                rd_mux[`THS_ST_ACT]  = act_reg[sel_tc_reg];
                rd_mux[`THS_ST_HALT] = halt_reg[sel_tc_reg];
                rd_mux[`THS_ST_DA]   = da_reg[sel_tc_reg];
                rd_mux[`THS_ST_PARK] = park_reg[sel_tc_reg];
                rd_mux[`THS_ST_BLK]  = blk_reg[sel_tc_reg];
                rd_mux[`THS_ST_SUSP] = susp_reg[sel_tc_reg];
                rd_mux[`THS_ST_VPE_LSB +: VW] = vpe_reg[sel_tc_reg];
            end
            `THS_OFF_PC:    rd_mux = pc_reg[sel_tc_reg];
            `THS_OFF_STATUS: begin
                rd_mux[`THS_SR_CU_LSB +: 4]  = cu_reg[sel_tc_reg];
                rd_mux[`THS_SR_MX]           = mx_reg[sel_tc_reg];
                rd_mux[`THS_SR_KSU_LSB +: 2] = ksu_reg[sel_tc_reg];
                rd_mux[`THS_SR_SST]          = sst_reg[sel_tc_reg];
                rd_mux[`THS_SR_ADDRESS_SPACE_ID_LSB +: 8] = address_space_id_reg[sel_tc_reg];
            end
            `THS_OFF_TPTR:  rd_mux = tptr_reg[sel_tc_reg];
            `THS_OFF_GIDX:  rd_mux[GW-1:0] = gidx_reg;
            `THS_OFF_GDATA: rd_mux = gpr_mem[sel_tc_reg][gidx_reg]; // RULE14
            `THS_OFF_MHI:   rd_mux = mhi_reg[sel_tc_reg];
            `THS_OFF_MLO:   rd_mux = mlo_reg[sel_tc_reg];
            `THS_OFF_ELIG:  rd_mux[N_TC-1:0] = eligible;
            `THS_OFF_VSYS:  rd_mux = vsys_reg[sel_vpe_reg];
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ahb_take && !hwrite) begin
            hrdata <= hprot[1] ? rd_mux : 32'h0000_0000; // RULE14
        end
    end

    // ---------------------------------------------------------------
    // Selection and configuration registers
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_reg     <= 1'b0;
            ven_reg     <= N_VPE'(`THS_RST_VPE_EN); // RULE17
            sel_tc_reg  <= '0;
            sel_vpe_reg <= '0;
            gidx_reg    <= '0;
        end else if (wr_en) begin
            case (wr_addr_reg)
                `THS_OFF_CTRL: begin
                    cfg_reg <= hwdata[`THS_CTRL_CFG];
                    ven_reg <= hwdata[`THS_CTRL_VEN_LSB +: N_VPE];
                end
                `THS_OFF_SEL: begin
                    sel_tc_reg  <= hwdata[TW-1:0];
                    sel_vpe_reg <= hwdata[`THS_SEL_VPE_LSB +: VW];
                end
                `THS_OFF_GIDX: gidx_reg <= hwdata[GW-1:0];
                default: ;
            endcase
        end
    end

    // Legacy system state, one copy per element
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int v = 0; v < N_VPE; v++) begin
                vsys_reg[v] <= 32'h0000_0000;
            end
        end else if (wr_en && wr_addr_reg == `THS_OFF_VSYS) begin
            vsys_reg[sel_vpe_reg] <= hwdata; // RULE2
        end
    end

    // ---------------------------------------------------------------
    // Binding, creation and thread_instr_a decisions
    // ---------------------------------------------------------------
    logic              bind_ok;
    logic [VW-1:0]     bind_vpe;
    logic              cr_found;
    logic [TW-1:0]     cr_tgt;
    logic              cr_take;
    logic              yd_take;

    assign bind_vpe = hwdata[`THS_ST_VPE_LSB +: VW];

    always_comb begin
        int cnt;
        cnt = 0;
        for (int j = 0; j < N_TC; j++) begin
            if (vpe_reg[j] == vpe_reg[sel_tc_reg]) begin
                cnt = cnt + 1;
            end
        end
        bind_ok = cfg_reg && (cnt > 1) && (int'(bind_vpe) < N_VPE); // RULE18 RULE3
    end

    always_comb begin
        cr_found = 1'b0;
        cr_tgt   = '0;
        for (int j = N_TC - 1; j >= 0; j--) begin
            if (!act_reg[j] && da_reg[j] && !halt_reg[j] &&
                vpe_reg[j] == vpe_reg[create_src]) begin // RULE6 RULE7 RULE10
                cr_found = 1'b1;
                cr_tgt   = TW'(j);
            end
        end
    end

    assign cr_take = create_valid && cr_found && act_reg[create_src]; // RULE8
    assign yd_take = thread_instr_a_valid && da_reg[thread_instr_a_src] &&
                     act_reg[thread_instr_a_src]; // RULE7 RULE8

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            create_done <= 1'b0;
            create_ok   <= 1'b0;
            create_tc   <= '0;
            thread_instr_a_done  <= 1'b0;
            thread_instr_a_ok    <= 1'b0;
        end else begin
            create_done <= create_valid;
            create_ok   <= cr_take;
            create_tc   <= cr_tgt;
            thread_instr_a_done  <= thread_instr_a_valid;
            thread_instr_a_ok    <= yd_take;
        end
    end

    // ---------------------------------------------------------------
    // Context state flags
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < N_TC; i++) begin
                act_reg[i]  <= (i == 0); // RULE17
                halt_reg[i] <= 1'b0;
                da_reg[i]   <= 1'b0;
                park_reg[i] <= 1'b0;
                blk_reg[i]  <= 1'b0;
                susp_reg[i] <= 1'b0;
                vpe_reg[i]  <= VW'(i % N_VPE); // RULE3
            end
        end else begin
            for (int i = 0; i < N_TC; i++) begin
                if (wr_state && sel_tc_reg == TW'(i)) begin
                    act_reg[i]  <= hwdata[`THS_ST_ACT]; // RULE8
                    halt_reg[i] <= hwdata[`THS_ST_HALT];
                    da_reg[i]   <= hwdata[`THS_ST_DA];
                    park_reg[i] <= hwdata[`THS_ST_PARK]; // RULE13
                    if (bind_ok) begin
                        vpe_reg[i] <= bind_vpe; // RULE18
                    end
                end
                if (cr_take && cr_tgt == TW'(i)) begin
                    act_reg[i] <= 1'b1; // RULE6
                end
                if (yd_take && thread_instr_a_src == TW'(i)) begin
                    act_reg[i] <= 1'b0; // RULE7
                end
                if (block_set[i] && act_reg[i]) begin
                    blk_reg[i] <= 1'b1; // RULE9 RULE15
                end else if (block_clr[i] || !act_reg[i]) begin
                    blk_reg[i] <= 1'b0;
                end
                susp_reg[i] <= suspend_in[i] && act_reg[i]; // RULE12
            end
        end
    end

    // ---------------------------------------------------------------
    // Per-context program counter and status fields
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < N_TC; i++) begin
                pc_reg[i] <= RESET_PC; // RULE17
            end
        end else begin
            if (pc_upd_valid && !halt_reg[pc_upd_tc]) begin
                pc_reg[pc_upd_tc] <= pc_upd_value; // RULE11
            end
            if (wr_pc) begin
                pc_reg[sel_tc_reg] <= hwdata; // RULE14
            end
            if (cr_take) begin
                pc_reg[cr_tgt] <= create_pc;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < N_TC; i++) begin
                cu_reg[i]   <= 4'h0; // RULE1
                mx_reg[i]   <= 1'b0;
                ksu_reg[i]  <= ths_pkg::ths_ksu_e'(`THS_RST_KSU);
                sst_reg[i]  <= 1'b0;
                address_space_id_reg[i] <= 8'h00;
                tptr_reg[i] <= 32'h0000_0000;
                mhi_reg[i]  <= 32'h0000_0000;
                mlo_reg[i]  <= 32'h0000_0000;
            end
        end else if (wr_en) begin
            case (wr_addr_reg)
                `THS_OFF_STATUS: begin
                    cu_reg[sel_tc_reg]  <= hwdata[`THS_SR_CU_LSB +: 4];
                    mx_reg[sel_tc_reg]  <= hwdata[`THS_SR_MX];
                    ksu_reg[sel_tc_reg] <=
                        ths_pkg::ths_ksu_e'(hwdata[`THS_SR_KSU_LSB +: 2]);
                    sst_reg[sel_tc_reg] <= hwdata[`THS_SR_SST];
                    address_space_id_reg[sel_tc_reg] <= hwdata[`THS_SR_ADDRESS_SPACE_ID_LSB +: 8];
                end
                `THS_OFF_TPTR: tptr_reg[sel_tc_reg] <= hwdata;
                `THS_OFF_MHI:  mhi_reg[sel_tc_reg]  <= hwdata;
                `THS_OFF_MLO:  mlo_reg[sel_tc_reg]  <= hwdata;
                default: ;
            endcase
        end
    end

    // General registers, one bank per context
    always_ff @(posedge hclk) begin
        if (wb_valid && !halt_reg[wb_tc]) begin
            gpr_mem[wb_tc][wb_idx] <= wb_data; // RULE1 RULE11
        end
        if (wr_en && wr_addr_reg == `THS_OFF_GDATA) begin
            gpr_mem[sel_tc_reg][gidx_reg] <= hwdata; // RULE14
        end
    end

    // ---------------------------------------------------------------
    // Eligibility and round-robin selection
    // ---------------------------------------------------------------
    logic [N_TC-1:0]   elig;
    logic              nxt_found;
    logic [TW-1:0]     nxt_tc;

    for (genvar g = 0; g < N_TC; g++) begin : g_elig
        assign elig[g] = act_reg[g] && !halt_reg[g] && !blk_reg[g] &&
                         !susp_reg[g] && !park_reg[g] &&
                         ven_reg[vpe_reg[g]]; // RULE19 RULE4 RULE5
    end

    always_comb begin
        int idx;
        idx       = 0;
        nxt_found = 1'b0;
        nxt_tc    = last_reg;
        for (int k = N_TC; k >= 1; k--) begin
            idx = (int'(last_reg) + k) % N_TC;
            if (elig[idx]) begin
                nxt_found = 1'b1; // RULE16
                nxt_tc    = TW'(idx);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_reg    <= '0;
            issue_valid <= 1'b0;
            issue_tc    <= '0;
            issue_pc    <= 32'h0000_0000;
            eligible    <= '0;
            exc_permit  <= '0;
        end else begin
            if (nxt_found) begin
                last_reg <= nxt_tc;
            end
            issue_valid <= nxt_found; // RULE5
            issue_tc    <= nxt_tc;
            issue_pc    <= pc_reg[nxt_tc];
            eligible    <= elig;
            exc_permit  <= act_reg & ~susp_reg & ~halt_reg; // RULE12
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_issue_is_eligible: assert property ( // RULE5
        issue_valid |-> eligible[issue_tc])
        else $error("issued context was not eligible");
    // Per-context checks
    for (genvar g = 0; g < N_TC; g++) begin : g_ctx_chk
        a_free_not_sched: assert property ( // RULE4
            !act_reg[g] |=> !eligible[g])
            else $error("free context marked eligible");
        a_halt_not_sched: assert property ( // RULE10
            halt_reg[g] |=> !eligible[g] &&
            !(issue_valid && issue_tc == TW'(g)))
            else $error("halted context scheduled");
        a_park_not_sched: assert property ( // RULE13
            park_reg[g] |=> !eligible[g])
            else $error("parked context eligible");
        a_block_holds: assert property ( // RULE9
            block_set[g] && act_reg[g] |=> blk_reg[g] ##1 !eligible[g])
            else $error("blocked context not held");
        a_halt_pc_stable: assert property ( // RULE11
            halt_reg[g] && !wr_pc && !(cr_take && cr_tgt == TW'(g)) |=>
            $stable(pc_reg[g]))
            else $error("halted context counter moved");
        a_susp_no_exc: assert property ( // RULE12
            susp_reg[g] |=> !exc_permit[g])
            else $error("suspended context may raise exceptions");
    end
    a_create_free_da: assert property ( // RULE6
        cr_take |=> create_ok && act_reg[create_tc] && da_reg[create_tc])
        else $error("creation result wrong");
    a_thread_instr_a_needs_da: assert property ( // RULE7
        thread_instr_a_valid && !da_reg[thread_instr_a_src] |=> thread_instr_a_done && !thread_instr_a_ok)
        else $error("thread_instr_a on non-allocatable context");
    a_bind_cfg_only: assert property ( // RULE18
        !cfg_reg |=> $stable(vpe_reg))
        else $error("binding changed outside config state");

    c_issue:      cover property (issue_valid ##1 issue_valid);
    c_create_ok:  cover property (create_done && create_ok);
    c_create_bad: cover property (create_done && !create_ok);
    c_thread_instr_a_ok:   cover property (thread_instr_a_done && thread_instr_a_ok);

endmodule

/* bench/ths_pipe_model.sv */
// Fetch and issue pipeline model that steps issued program counters
`timescale 1ns/10ps
module ths_pipe_model (
    input  wire logic        hclk,
    input  wire logic        run,
    input  wire logic        issue_valid,
    input  wire logic [1:0]  issue_tc,
    input  wire logic [31:0] issue_pc,
    output logic             pc_upd_valid,
    output logic      [1:0]  pc_upd_tc,
    output logic      [31:0] pc_upd_value
);
    // ---------------------------------------------------------------
    // Program counter writeback of the issued context
    // ---------------------------------------------------------------
    initial pc_upd_valid = 1'b0;
    always @(posedge hclk) begin
        pc_upd_valid <= run && issue_valid;
        pc_upd_tc    <= issue_tc;
        pc_upd_value <= issue_pc + 32'h0000_0004;
    end
endmodule

/* bench/testbench.sv */
// Self-checking bench for the thread context scheduler
`timescale 1ns/10ps
`include "ths_defs.svh"
module testbench;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [3:0] hprot = 4'h3;
    logic hready, hreadyout, hresp, run = 1'b0;
    logic pc_upd_valid, wb_valid = 1'b0, create_valid = 1'b0;
    logic [1:0] pc_upd_tc, wb_tc = 2'h0, create_src = 2'h0, thread_instr_a_src = 2'h0;
    logic [31:0] pc_upd_value, wb_data = 32'h0, create_pc = 32'h0;
    logic [4:0] wb_idx = 5'h0;
    logic [3:0] block_set = 4'h0, block_clr = 4'h0, suspend_in = 4'h0;
    logic thread_instr_a_valid = 1'b0, create_done, create_ok, thread_instr_a_done, thread_instr_a_ok;
    logic [1:0] create_tc, issue_tc;
    logic issue_valid;
    logic [31:0] issue_pc;
    logic [3:0] eligible, exc_permit;
    int errors = 0, n_tests = 0;
    assign hready = hreadyout;
    always #20 hclk = ~hclk;
    ths_sched DUT (.*);
    ths_pipe_model PIPE (.*);
    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic p);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h00_0000, a};
        hprot  <= {2'h0, p, 1'b1};
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic settle;
        repeat (3) @(posedge hclk);
        #1;
    endtask
    task automatic create(input logic [1:0] src, input logic ok);
        @(posedge hclk);
        create_valid <= 1'b1;
        create_src   <= src;
        create_pc    <= 32'h0000_0100;
        @(posedge hclk);
        create_valid <= 1'b0;
        #1;
        chk(create_done, 1'b1);
        chk(create_ok, ok);
    endtask
    task automatic thread_instr_a(input logic [1:0] src, input logic ok);
        @(posedge hclk);
        thread_instr_a_valid <= 1'b1;
        thread_instr_a_src   <= src;
        @(posedge hclk);
        thread_instr_a_valid <= 1'b0;
        #1;
        chk(thread_instr_a_done, 1'b1);
        chk(thread_instr_a_ok, ok);
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset;
        settle;
        chk(eligible, 4'h1);
        chk(issue_tc, 2'h0);
        chk(exc_permit, 4'h1);
        chk(issue_valid, 1'b1);
        chk(issue_pc, 32'h0);
        @(posedge hclk);
        run <= 1'b1;
    endtask
    task automatic t_alloc;
        create(2'h0, 1'b0);
        bus(1'b1, `THS_OFF_SEL, 32'h2, 1'b1);
        bus(1'b1, `THS_OFF_STATE, 32'h4, 1'b1);
        create(2'h0, 1'b1);
        chk(create_tc, 2'h2);
        settle;
        chk(eligible, 4'h5);
        create(2'h0, 1'b0);
    endtask
    task automatic t_flags;
        @(posedge hclk);
        block_set <= 4'h4;
        @(posedge hclk);
        block_set <= 4'h0;
        settle;
        chk(eligible, 4'h1);
        @(posedge hclk);
        block_clr <= 4'h4;
        @(posedge hclk);
        block_clr <= 4'h0;
        settle;
        chk(eligible, 4'h5);
        bus(1'b1, `THS_OFF_STATE, 32'h7, 1'b1);
        settle;
        chk({exc_permit, eligible}, 8'h11);
        bus(1'b1, `THS_OFF_STATE, 32'hD, 1'b1);
        settle;
        chk({exc_permit, eligible}, 8'h51);
        bus(1'b1, `THS_OFF_STATE, 32'h5, 1'b1);
        @(posedge hclk);
        suspend_in <= 4'h4;
        settle;
        chk({exc_permit, eligible}, 8'h11);
        @(posedge hclk);
        suspend_in <= 4'h0;
    endtask
    task automatic t_thread_instr_a;
        thread_instr_a(2'h2, 1'b1);
        settle;
        chk(eligible, 4'h1);
        thread_instr_a(2'h0, 1'b0);
    endtask
    task automatic t_regs;
        bus(1'b1, `THS_OFF_SEL, 32'h3, 1'b1);
        bus(1'b1, `THS_OFF_PC, 32'h1234_5678, 1'b1);
        bus(1'b0, `THS_OFF_PC, 32'h0, 1'b1);
        chk(rd, 32'h1234_5678);
        bus(1'b1, `THS_OFF_GIDX, 32'h5, 1'b1);
        for (int i = 0; i < 2; i++) begin
            @(posedge hclk);
            wb_valid <= 1'b1;
            wb_tc    <= 2'h3;
            wb_idx   <= 5'h05;
            wb_data  <= 32'hA5A5_0000 + i;
            @(posedge hclk);
            wb_valid <= 1'b0;
            bus(1'b0, `THS_OFF_GDATA, 32'h0, 1'b1);
            chk(rd, 32'hA5A5_0000);
            bus(1'b1, `THS_OFF_STATE, 32'h2, 1'b1);
        end
        bus(1'b0, `THS_OFF_STATE, 32'h0, 1'b1);
        chk(rd, 32'h0000_0102);
        bus(1'b0, `THS_OFF_PC, 32'h0, 1'b0);
        chk(rd, 32'h0);
        chk(hresp, 1'b0);
        bus(1'b0, 8'h40, 32'h0, 1'b1);
        chk(rd, 32'h0);
    endtask
    task automatic t_cfg;
        bus(1'b1, `THS_OFF_STATE, 32'h0, 1'b1);
        bus(1'b0, `THS_OFF_STATE, 32'h0, 1'b1);
        chk(rd, 32'h100);
        bus(1'b1, `THS_OFF_CTRL, 32'h301, 1'b1);
        bus(1'b1, `THS_OFF_STATE, 32'h0, 1'b1);
        bus(1'b0, `THS_OFF_STATE, 32'h0, 1'b1);
        chk(rd, 32'h0);
        bus(1'b1, `THS_OFF_SEL, 32'h101, 1'b1);
        bus(1'b1, `THS_OFF_STATE, 32'h0, 1'b1);
        bus(1'b1, `THS_OFF_VSYS, 32'h5A, 1'b1);
        bus(1'b0, `THS_OFF_STATE, 32'h0, 1'b1);
        chk(rd, 32'h100);
        bus(1'b0, `THS_OFF_VSYS, 32'h0, 1'b1);
        chk(rd, 32'h5A);
        bus(1'b1, `THS_OFF_SEL, 32'h1, 1'b1);
        bus(1'b0, `THS_OFF_VSYS, 32'h0, 1'b1);
        chk(rd, 32'h0);
    endtask
    task automatic report_and_stop;
        if (errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // Sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_alloc;
        t_flags;
        t_thread_instr_a;
        t_regs;
        t_cfg;
        report_and_stop;
    end
    initial begin
        #200000;
        errors++;
        report_and_stop;
    end
endmodule
